/* File: src/sscf_consts.vh */
// Constants for the serial clock, frame-sync and pin-control block.
// Assumes inclusion by sscf_top.v and sscf_bitclk.v only.
`ifndef SSCF_CONSTS_VH
`define SSCF_CONSTS_VH
`define SSCF_ADDR_CLOCK_FRAME 2'h0
`define SSCF_ADDR_PIN_MODE 2'h1
`define SSCF_ADDR_STATUS 2'h2
`define SSCF_ADDR_CONTROL 2'h3
`define SSCF_REG_RESET 16'h0000
`define SSCF_PM_LSB 0
`define SSCF_PM_MSB 7
`define SSCF_DC_LSB 8
`define SSCF_DC_MSB 12
`define SSCF_WL_LSB 13
`define SSCF_WL_MSB 14
`define SSCF_PSR_BIT 15
`define SSCF_OF0_BIT 0
`define SSCF_OF1_BIT 1
`define SSCF_DIR0_BIT 2
`define SSCF_DIR1_BIT 3
`define SSCF_DIR2_BIT 4
`define SSCF_CKD_BIT 5
`define SSCF_ORDER_BIT 6
`define SSCF_FSL_LSB 7
`define SSCF_FSL_MSB 8
`define SSCF_SYNC_BIT 9
`define SSCF_GATE_BIT 10
`define SSCF_NET_BIT 11
`define SSCF_CTRL_SWRESET_BIT 0
`define SSCF_FIXED_DIV 2'h1
`define SSCF_RANGE_DIV 3'h7
`define SSCF_WL8 5'h08
`define SSCF_WL12 5'h0c
`define SSCF_WL16 5'h10
`define SSCF_WL24 5'h18
`endif

/* File: src/sscf_bitclk.v */
// Internal bit clock generator: fixed divide by two (two cycles per half period),
// optional divide by eight,
// then a divide by modulus plus one. Emits one-cycle tick pulses on both edges.
`default_nettype none
`include "sscf_consts.vh"
module sscf_bitclk (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    input wire sw_clear,
    // Settings
    input wire [7:0] modulus,
    input wire range_en,
    // Bit clock out
    output reg bclk_ff,
    output wire rise_tick,
    output wire fall_tick
);
    reg [1:0] quarter_ff;
    reg [2:0] eighth_ff;
    reg [7:0] mod_ff;
    wire q_tick;
    wire r_tick;
    wire m_tick;

    assign q_tick = (quarter_ff == `SSCF_FIXED_DIV);
    assign r_tick = q_tick & (!range_en | (eighth_ff == `SSCF_RANGE_DIV));
    assign m_tick = r_tick & (mod_ff >= modulus);
    // Half period edge pairs give fosc/4 per full bit at fastest settings
    assign rise_tick = m_tick & !bclk_ff;
    assign fall_tick = m_tick & bclk_ff;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quarter_ff <= 2'h0;
            eighth_ff <= 3'h0;
            mod_ff <= 8'h00;
            bclk_ff <= 1'b0;
        end else if (sw_clear) begin
            quarter_ff <= 2'h0;
            eighth_ff <= 3'h0;
            mod_ff <= 8'h00;
            bclk_ff <= 1'b0;
        end else begin
            quarter_ff <= q_tick ? 2'h0 : quarter_ff + 2'h1;
            if (q_tick) begin
                eighth_ff <= eighth_ff + 3'h1;
            end
            if (r_tick) begin
                mod_ff <= m_tick ? 8'h00 : mod_ff + 8'h01;
            end
            if (m_tick) begin
                bclk_ff <= !bclk_ff;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/sscf_top.v */
// Clock, frame-sync and control-pin logic of a synchronous serial port.
// Assumes a plain register port and pins outside the clk domain.
`default_nettype none
`include "sscf_consts.vh"
module sscf_top (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port
    input wire [1:0] reg_addr,
    input wire [23:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [23:0] reg_rdata_ff,
    // Transmit word hand-off from the data path
    input wire xmit_load,
    input wire xmit_pending,
    output wire slot_start,
    output wire frame_start,
    output wire [4:0] word_bits,
    output wire bit_order,
    // Shift clocks to the data path
    output wire xmit_shift_tick,
    output wire rcv_shift_tick,
    output wire rcv_sync,
    // Serial clock pin
    input wire sclk_in,
    output wire sclk_out,
    output wire sclk_oe,
    // Control pin zero
    input wire ctrl_pin_zero_in,
    output wire ctrl_pin_zero_out,
    output wire ctrl_pin_zero_oe,
    // Control pin one
    input wire ctrl_pin_one_in,
    output wire ctrl_pin_one_out,
    output wire ctrl_pin_one_oe,
    // Control pin two
    input wire ctrl_pin_two_in,
    output wire ctrl_pin_two_out,
    output wire ctrl_pin_two_oe
);
    reg [15:0] clock_frame_control_ff;
    reg [15:0] pin_mode_control_ff;
    reg [1:0] flag_buf_ff;
    reg [1:0] flag_pin_ff;
    reg [4:0] bit_cnt_ff;
    reg [4:0] slot_cnt_ff;
    reg tx_fs_ff;
    reg rx_fs_ff;
    reg [1:0] sclk_s_ff;
    reg sclk_prev_ff;
    reg [1:0] p0_s_ff;
    reg [1:0] p1_s_ff;
    reg [1:0] p2_s_ff;
    reg fs_ext_prev_ff;
    reg run_ff;
    reg [23:0] nxt_rdata;
    wire sw_clear;
    wire [7:0] modulus;
    wire [4:0] frame_div;
    wire [1:0] wsize;
    wire [1:0] fsl;
    wire dir0;
    wire dir1;
    wire dir2;
    wire ckd;
    wire common;
    wire burst;
    wire network;
    wire int_clk;
    wire int_rise;
    wire int_fall;
    wire ext_rise;
    wire ext_fall;
    wire bit_rise;
    wire bit_fall;
    wire word_end;
    wire frame_end;
    wire ext_fs_edge;
    wire int_frame;
    wire tx_one_bit;
    wire rx_one_bit;

    assign sw_clear = reg_wr & (reg_addr == `SSCF_ADDR_CONTROL) &
        reg_wdata[`SSCF_CTRL_SWRESET_BIT];
    assign modulus = clock_frame_control_ff[`SSCF_PM_MSB:`SSCF_PM_LSB];
    assign frame_div = clock_frame_control_ff[`SSCF_DC_MSB:`SSCF_DC_LSB];
    assign wsize = clock_frame_control_ff[`SSCF_WL_MSB:`SSCF_WL_LSB];
    assign fsl = pin_mode_control_ff[`SSCF_FSL_MSB:`SSCF_FSL_LSB];
    assign dir0 = pin_mode_control_ff[`SSCF_DIR0_BIT];
    assign dir1 = pin_mode_control_ff[`SSCF_DIR1_BIT];
    assign dir2 = pin_mode_control_ff[`SSCF_DIR2_BIT];
    assign ckd = pin_mode_control_ff[`SSCF_CKD_BIT];
    assign common = pin_mode_control_ff[`SSCF_SYNC_BIT];
    assign burst = pin_mode_control_ff[`SSCF_GATE_BIT];
    assign network = pin_mode_control_ff[`SSCF_NET_BIT];
    assign bit_order = pin_mode_control_ff[`SSCF_ORDER_BIT];

    // Control registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_frame_control_ff <= `SSCF_REG_RESET;
            pin_mode_control_ff <= `SSCF_REG_RESET;
        end else if (sw_clear) begin
            clock_frame_control_ff <= `SSCF_REG_RESET;
            pin_mode_control_ff <= `SSCF_REG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `SSCF_ADDR_CLOCK_FRAME) begin
                clock_frame_control_ff <= reg_wdata[15:0];
            end
            if (reg_addr == `SSCF_ADDR_PIN_MODE) begin
                pin_mode_control_ff <= reg_wdata[15:0];
            end
        end
    end

    always @* begin
        nxt_rdata = 24'h000000;
        case (reg_addr)
            `SSCF_ADDR_CLOCK_FRAME: nxt_rdata = {8'h00, clock_frame_control_ff};
            `SSCF_ADDR_PIN_MODE: nxt_rdata = {8'h00, pin_mode_control_ff};
            `SSCF_ADDR_STATUS: nxt_rdata = {16'h0000, p1_s_ff[1], p0_s_ff[1], flag_buf_ff,
                tx_fs_ff, rx_fs_ff, run_ff, sclk_out};
            default: nxt_rdata = 24'h000000;
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_ff <= 24'h000000;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : 24'h000000;
        end
    end

    // Internal bit clock
    sscf_bitclk u_bitclk (
        .clk(clk),
        .reset_n(reset_n),
        .sw_clear(sw_clear),
        .modulus(modulus),
        .range_en(clock_frame_control_ff[`SSCF_PSR_BIT]),
        .bclk_ff(int_clk),
        .rise_tick(int_rise),
        .fall_tick(int_fall)
    );

    // Pin synchronisers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_s_ff <= 2'h0;
            p0_s_ff <= 2'h0;
            p1_s_ff <= 2'h0;
            p2_s_ff <= 2'h0;
            sclk_prev_ff <= 1'b0;
            fs_ext_prev_ff <= 1'b0;
        end else begin
            sclk_s_ff <= {sclk_s_ff[0], sclk_in};
            p0_s_ff <= {p0_s_ff[0], ctrl_pin_zero_in};
            p1_s_ff <= {p1_s_ff[0], ctrl_pin_one_in};
            p2_s_ff <= {p2_s_ff[0], ctrl_pin_two_in};
            sclk_prev_ff <= sclk_s_ff[1];
            fs_ext_prev_ff <= p2_s_ff[1];
        end
    end

    assign ext_rise = sclk_s_ff[1] & !sclk_prev_ff;
    assign ext_fall = !sclk_s_ff[1] & sclk_prev_ff;
    // Clock source select; burst mode stops edges when not running and no data is pending
    assign bit_rise = (ckd ? int_rise : ext_rise) & (!burst | run_ff | xmit_pending);
    assign bit_fall = (ckd ? int_fall : ext_fall) & (!burst | run_ff);
    assign sclk_out = ckd & (!burst | run_ff) & int_clk;
    assign sclk_oe = ckd;
    assign xmit_shift_tick = bit_rise;
    assign rcv_shift_tick = common ? bit_fall : 1'b0;

    // Word length
    assign word_bits = (wsize == 2'h0) ? `SSCF_WL8 : (wsize == 2'h1) ? `SSCF_WL12 :
        (wsize == 2'h2) ? `SSCF_WL16 : `SSCF_WL24;

    assign word_end = bit_rise & (bit_cnt_ff == word_bits - 5'h01);
    assign frame_end = word_end & (slot_cnt_ff == frame_div);
    assign ext_fs_edge = p2_s_ff[1] & !fs_ext_prev_ff & !dir2 & !burst;
    assign int_frame = dir2 | burst;
    assign slot_start = word_end;
    assign frame_start = int_frame ? frame_end : ext_fs_edge;
    assign tx_one_bit = fsl[1] ^ fsl[0];
    assign rx_one_bit = fsl[1];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_ff <= 5'h00;
            slot_cnt_ff <= 5'h00;
            tx_fs_ff <= 1'b0;
            rx_fs_ff <= 1'b0;
            run_ff <= 1'b0;
            flag_buf_ff <= 2'h0;
            flag_pin_ff <= 2'h0;
        end else if (sw_clear) begin
            bit_cnt_ff <= 5'h00;
            slot_cnt_ff <= 5'h00;
            tx_fs_ff <= 1'b0;
            rx_fs_ff <= 1'b0;
            run_ff <= 1'b0;
            flag_buf_ff <= 2'h0;
            flag_pin_ff <= 2'h0;
        end else begin
            if (!int_frame && ext_fs_edge) begin
                bit_cnt_ff <= 5'h00;
                slot_cnt_ff <= 5'h00;
            end else if (word_end) begin
                bit_cnt_ff <= 5'h00;
                slot_cnt_ff <= (slot_cnt_ff == frame_div) ? 5'h00 : slot_cnt_ff + 5'h01;
            end else if (bit_rise) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
            // Burst clock starts on a pending word and runs until a word ends with no word pending
            if (burst && bit_rise && !run_ff && xmit_pending) begin
                run_ff <= 1'b1;
            end else if (word_end && !xmit_pending) begin
                run_ff <= 1'b0;
            end
            // Internal sync width: one bit or one word
            if (frame_end) begin
                tx_fs_ff <= 1'b1;
                rx_fs_ff <= 1'b1;
            end else if (bit_rise) begin
                if (tx_one_bit || word_end) begin
                    tx_fs_ff <= 1'b0;
                end
                if (rx_one_bit || word_end) begin
                    rx_fs_ff <= 1'b0;
                end
            end
            // Flags take new values only as the transmit word is loaded
            if (xmit_load) begin
                flag_buf_ff <= pin_mode_control_ff[`SSCF_OF1_BIT:`SSCF_OF0_BIT];
            end
            // Loaded flags reach the pins at frame start, or at slot start in network mode
            if (network ? slot_start : frame_start) begin
                flag_pin_ff <= flag_buf_ff;
            end
        end
    end

    assign rcv_sync = int_frame ? (common ? tx_fs_ff : rx_fs_ff) : p2_s_ff[1];
    assign ctrl_pin_two_out = tx_fs_ff;
    assign ctrl_pin_two_oe = dir2;
    // Flags in common mode, otherwise receive clock and receive sync
    assign ctrl_pin_zero_oe = dir0;
    assign ctrl_pin_zero_out = common ? flag_pin_ff[0] : int_clk;
    assign ctrl_pin_one_oe = dir1;
    assign ctrl_pin_one_out = common ? flag_pin_ff[1] : rx_fs_ff;
endmodule
`default_nettype wire

/* File: tb/sscf_checker.sv */
// Checker for sscf_top: register read-back and pin direction.
// Assumes bind to sscf_top; shadows track writes on the register port.
`default_nettype none
module sscf_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [23:0] reg_rdata_ff,
    // Watched outputs
    input wire logic [4:0] word_bits,
    input wire logic bit_order,
    input wire logic rcv_shift_tick,
    input wire logic sclk_oe,
    input wire logic ctrl_pin_zero_oe,
    input wire logic ctrl_pin_one_oe,
    input wire logic ctrl_pin_two_oe
);
    logic [15:0] a_ff, b_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n || (reg_wr && reg_addr == 2'h3 && reg_wdata[0])) begin
            a_ff <= 16'h0000;
            b_ff <= 16'h0000;
        end else if (reg_wr && reg_addr == 2'h0) begin
            a_ff <= reg_wdata[15:0];
        end else if (reg_wr && reg_addr == 2'h1) begin
            b_ff <= reg_wdata[15:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rd_a_s; reg_rd && reg_addr == 2'h0; endsequence
    sequence rd_b_s; reg_rd && reg_addr == 2'h1; endsequence
    rd_upper_zero_a: assert property (reg_rd |=> reg_rdata_ff[23:16] == 8'h00)
        else $error("read upper byte not zero");
    rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata_ff == 24'h0)
        else $error("read data outside read cycle");
    rd_clock_frame_a: assert property (rd_a_s |=> reg_rdata_ff == {8'h00, $past(a_ff)})
        else $error("clock frame read back wrong");
    rd_pin_mode_a: assert property (rd_b_s |=> reg_rdata_ff == {8'h00, $past(b_ff)})
        else $error("pin mode read back wrong");
    pin_dirs_a: assert property ({ctrl_pin_one_oe, ctrl_pin_zero_oe} == b_ff[3:2])
        else $error("pin zero or one direction wrong");
    sync_dir_a: assert property (ctrl_pin_two_oe == b_ff[4])
        else $error("pin two direction wrong");
    sclk_dir_a: assert property (sclk_oe == b_ff[5])
        else $error("clock pin direction wrong");
    order_a: assert property (bit_order == b_ff[6])
        else $error("bit order wrong");
    word_size_a: assert property (word_bits == (a_ff[14] ? (a_ff[13] ? 5'h18 : 5'h10) :
        (a_ff[13] ? 5'h0c : 5'h08))) else $error("word size wrong");
    rcv_common_a: assert property (rcv_shift_tick |-> b_ff[9])
        else $error("receive tick without common clocking");
endmodule
bind sscf_top sscf_checker sscf_checker_i (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .word_bits(word_bits), .bit_order(bit_order),
    .rcv_shift_tick(rcv_shift_tick), .sclk_oe(sclk_oe), .ctrl_pin_zero_oe(ctrl_pin_zero_oe),
    .ctrl_pin_one_oe(ctrl_pin_one_oe), .ctrl_pin_two_oe(ctrl_pin_two_oe));
`default_nettype wire

/* File: tb/sscf_codec.sv */
// Far-side serial device: external bit clock and control pin levels.
// Assumes the device's pin enables are high while it drives.
`default_nettype none
module sscf_codec (
    // Clock and control
    input wire logic clk,
    input wire logic run,
    // Device pin drives
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    // Resolved pin levels
    output logic sclk_in,
    output logic [2:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_ff = 4'h0;
    logic clk_ff = 1'b0;
    logic [2:0] ext_ff = 3'h0;
    always @(posedge clk) begin
        cnt_ff <= run ? cnt_ff + 4'h1 : 4'h0;
        if (run && cnt_ff == 4'hf) clk_ff <= ~clk_ff;
        ext_ff <= ~ext_ff;
    end
    // Halves of 16 system clocks; clock stands low outside a run
    assign sclk_in = sclk_oe ? sclk_out : clk_ff & run;
    // Undriven pins show a changing pattern rather than a held value
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_ff);
endmodule
`default_nettype wire

/* File: tb/sscf_top_tb.sv */
// Self-checking bench for sscf_top over the register port.
// Assumes the codec model in sscf_codec.sv and a 50 MHz clock.
`default_nettype none
module sscf_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, xmit_load = 1'b0;
    logic xmit_pending = 1'b0, run = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [23:0] reg_wdata = 24'h0;
    wire [23:0] reg_rdata_ff;
    wire [4:0] word_bits;
    wire slot_start, frame_start, bit_order, xmit_shift_tick, rcv_shift_tick, rcv_sync;
    wire sclk_in, sclk_out, sclk_oe;
    wire [2:0] p_in, p_out, p_oe;
    int n_fail = 0, tests_run = 0, cyc = 0, i, n;
    logic [23:0] wlt [4] = '{24'h08, 24'h0c, 24'h10, 24'h18};
    logic [23:0] pa [4] = '{24'h0000, 24'h0002, 24'h8002, 24'h80ff};
    logic [23:0] pe [4] = '{24'h4, 24'hc, 24'h60, 24'h2000};
    sscf_top sscf_top_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .xmit_load(xmit_load), .xmit_pending(xmit_pending), .slot_start(slot_start),
        .frame_start(frame_start), .word_bits(word_bits), .bit_order(bit_order),
        .xmit_shift_tick(xmit_shift_tick), .rcv_shift_tick(rcv_shift_tick),
        .rcv_sync(rcv_sync), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .ctrl_pin_zero_in(p_in[0]), .ctrl_pin_zero_out(p_out[0]), .ctrl_pin_zero_oe(p_oe[0]),
        .ctrl_pin_one_in(p_in[1]), .ctrl_pin_one_out(p_out[1]), .ctrl_pin_one_oe(p_oe[1]),
        .ctrl_pin_two_in(p_in[2]), .ctrl_pin_two_out(p_out[2]), .ctrl_pin_two_oe(p_oe[2]));
    sscf_codec sscf_codec_i (.clk(clk), .run(run), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .pin_out(p_out), .pin_oe(p_oe), .sclk_in(sclk_in), .pin_in(p_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic cmp(input logic [23:0] g, input logic [23:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [23:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [23:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata_ff, e);
        @(posedge clk);
    endtask
    // Cycles between two rises: 0 bit clock, 1 frame start, 2 pin two, 3 slot, 4 rx sync
    task automatic per(input int sel, input logic [23:0] e);
        int k, t0;
        logic p, v;
        logic [4:0] s;
        p = 1'b1;
        t0 = -1;
        for (k = 0; k < 20000; k++) begin
            @(posedge clk);
            #1 s = {rcv_sync, slot_start, p_out[2], frame_start, sclk_out};
            v = s[sel];
            if (v === 1'b1 && p !== 1'b1) begin
                if (t0 >= 0) break;
                t0 = k;
            end
            p = v;
        end
        cmp(24'(k - t0), e);
    endtask
    // Waits for a frame start (sel 0) or slot start (sel 1), then two more edges
    task automatic wfs(input bit sel);
        int k;
        for (k = 0; k < 1000; k++) begin
            @(posedge clk);
            #1;
            if ((sel ? slot_start : frame_start) === 1'b1) break;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic ticks(input int c);
        n = 0;
        repeat (c) begin
            @(posedge clk);
            #1 n += (xmit_shift_tick === 1'b1);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(2'h0, 24'h0);
        rd(2'h1, 24'h0);
        wr(2'h0, 24'hffffff);
        rd(2'h0, 24'h00ffff);
        wr(2'h1, 24'hab0fff);
        wr(2'h2, 24'hffffff);
        rd(2'h1, 24'h000fff);
        wr(2'h3, 24'h000001);
        rd(2'h0, 24'h0);
        rd(2'h1, 24'h0);
        for (i = 0; i < 4; i++) begin
            wr(2'h0, {9'h0, 2'(i), 13'h0});
            cmp(24'(word_bits), wlt[i]);
        end
        wr(2'h1, 24'h00007c);
        cmp({sclk_oe, p_oe, bit_order}, 24'h1f);
        for (i = 0; i < 4; i++) begin
            wr(2'h0, pa[i]);
            per(1'b0, pe[i]);
        end
        wr(2'h1, 24'h000030);
        wr(2'h0, 24'h000100);
        per(1'b1, 24'h40);
        per(2, 24'h40);
        per(3, 24'h20);
        per(4, 24'h40);
        wr(2'h1, 24'h000130);
        wr(2'h0, 24'h000000);
        per(1'b1, 24'h20);
        xmit_pending <= 1'b1;
        wr(2'h0, 24'h000100);
        wr(2'h1, 24'h00022f);
        wfs(1'b0);
        cmp(24'(p_out[1:0]), 24'h0);
        xmit_load <= 1'b1;
        @(posedge clk);
        xmit_load <= 1'b0;
        wfs(1'b0);
        cmp(24'(p_out[1:0]), 24'h3);
        wr(2'h1, 24'h000a3c);
        xmit_load <= 1'b1;
        @(posedge clk);
        xmit_load <= 1'b0;
        wfs(1'b1);
        cmp(24'(p_out[1:0]), 24'h0);
        xmit_pending <= 1'b0;
        wr(2'h1, 24'h000420);
        repeat (100) @(posedge clk);
        ticks(200);
        cmp(24'(n), 24'h0);
        xmit_pending <= 1'b1;
        ticks(200);
        cmp(24'(n > 0), 24'h1);
        wr(2'h1, 24'h000000);
        run <= 1'b1;
        ticks(400);
        cmp(24'(n > 0), 24'h1);
        run <= 1'b0;
        print_verdict();
    end
endmodule
`default_nettype wire
